// >>> src/synth_pkg.sv
// Shared constants for the synthesizer serial programming link.
// Assumes both link ends and the bench import this package.
package synth_pkg;
    // Shift word and latch widths
    localparam int WORD_W = 24;
    localparam int CTRL_W = 16;
    localparam int NOISE_W = 11;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;
    // Integer/fraction latch fields
    localparam int INT_W = 9;
    localparam int FRAC_W = 12;
    localparam int FASTLOCK_BIT = 23;
    localparam int INT_MSB = 22;
    localparam int INT_LSB = 14;
    localparam int FRAC_MSB = 13;
    localparam int FRAC_LSB = 2;
    // Reference divider latch fields
    localparam int MODULUS_W = 12;
    localparam int RDIV_W = 4;
    localparam int MONSEL_W = 3;
    localparam int LOADSEL_BIT = 23;
    localparam int MONSEL_MSB = 22;
    localparam int MONSEL_LSB = 20;
    localparam int PRESCALER_BIT = 18;
    localparam int RDIV_MSB = 17;
    localparam int RDIV_LSB = 14;
    localparam int MODULUS_MSB = 13;
    localparam int MODULUS_LSB = 2;
    // Loop control latch fields
    localparam int DOUBLER_BIT = 11;
    localparam int POWERDOWN_BIT = 4;
    localparam int CNT_RESET_BIT = 2;
    // Reset values of the latches, then the accumulator and counter unit steps
    localparam logic [INT_W-1:0] INT_RESET = 9'h01f;
    localparam logic [FRAC_W-1:0] FRAC_RESET = 12'h000;
    localparam logic [MODULUS_W-1:0] MODULUS_RESET = 12'h002;
    localparam logic [RDIV_W-1:0] RDIV_RESET = 4'h1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [NOISE_W-1:0] NOISE_RESET = 11'h000;
    localparam logic [FRAC_W-1:0] ACC_ONE = 12'h001;
    localparam logic [INT_W:0] COUNT_ONE = 10'h001;
    // Lock detect: consecutive clean reference periods
    localparam int LOCK_COUNT = 4;
    localparam int LOCK_CNT_W = 3;
    // Latch select codes
    typedef enum logic [1:0] {
        SEL_INT_FRAC = 2'h0,
        SEL_REF_DIV = 2'h1,
        SEL_LOOP_CTRL = 2'h2,
        SEL_NOISE_SPUR = 2'h3
    } latch_sel_t;
    // Monitor output sources
    typedef enum logic [2:0] {
        MON_TRISTATE = 3'h0,
        MON_DIG_LOCK = 3'h1,
        MON_N_DIV = 3'h2,
        MON_HIGH = 3'h3,
        MON_R_DIV = 3'h4,
        MON_ANA_LOCK = 3'h5,
        MON_SPARE = 3'h6,
        MON_LOW = 3'h7
    } monitor_sel_t;
    // Host timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_PERIOD_NS = 160;
    localparam int SCLK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W = 8;
    localparam int BIT_CNT_W = 5;
    localparam int SHORT_BITS = 16;
    // Host register map
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam int WB_SEL_W = 4;
    localparam logic [WB_ADR_W-1:0] ADDR_TX_WORD = 8'h00;
    localparam logic [WB_ADR_W-1:0] ADDR_CTRL = 8'h04;
    localparam logic [WB_ADR_W-1:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_SHORT_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_MON_BIT = 1;
    // Host sequencer states
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_SHIFT = 4'h2,
        H_STROBE = 4'h4,
        H_GAP = 4'h8
    } host_state_t;
endpackage

// >>> src/synth_serial_if.sv
// Three-wire programming link plus the open-drain monitor line.
// Assumes a pull-up on the monitor line; resolved here from the enable.
`timescale 1ns/10ps
`default_nettype none
interface synth_serial_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic mon_out;
    logic mon_oe;
    wire logic mon_level;
    // Pull-up wins while nobody drives
    assign mon_level = mon_oe ? mon_out : 1'h1;
    modport device (input sclk, input sdata, input load_strobe, output mon_out, output mon_oe);
    modport host (output sclk, output sdata, output load_strobe, input mon_level);
endinterface
`default_nettype wire

// >>> src/level_sync.sv
// Two-stage synchroniser for one level.
// Assumes the input is stable for more than one destination clock.
`timescale 1ns/10ps
`default_nettype none
module level_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    // First stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= 1'h0;
            sync_out <= 1'h0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // level_sync
`default_nettype wire

// >>> src/synth_program_latches.sv
// Device end: serial shift register, four program latches, dividers,
// lock detect and monitor output.
// Assumes CLK_IN is the reference input and the host holds the serial
// clock still while the load strobe is high.
// Functional notes
// - Shift 24 bits MSB first on clock rise
// - Strobe rising edge copies word into one latch
// - Two lowest shifted bits select the latch
// - Codes: 00 int/frac, 01 ref, 10 ctrl, 11 noise
// - New modulus buffered until next int/frac write
// - Host writes int/frac after each modulus change
// - Reference divide ratio 1 to 15, divides reference
// - Integer value 9 bits, range 31 to 511
// - Modulus 12 bits, range 2 to 4095
// - Fraction 12 bits, zero to modulus minus one
// - Ratio int plus frac/modulus; reference times (1+D)/R
// - Int/frac word: fast-lock, integer, fraction fields
// - Ref word: load, monitor, prescaler, ratio, modulus
// - Monitor output selects lock or divider signals
// - Lock indication high with narrow low pulses
// - Power-down disconnects the reference input stage
`timescale 1ns/10ps
`default_nettype none
module synth_program_latches
    import synth_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic RF_IN,
    synth_serial_if.device LINK,
    output logic FASTLOCK_OUT,
    output logic [INT_W-1:0] INT_VALUE_OUT,
    output logic [FRAC_W-1:0] FRAC_VALUE_OUT,
    output logic [MODULUS_W-1:0] MODULUS_VALUE_OUT,
    output logic [RDIV_W-1:0] REF_RATIO_OUT,
    output logic PRESCALER_SELECT_OUT,
    output logic [CTRL_W-1:0] LOOP_CONTROL_OUT,
    output logic [NOISE_W-1:0] NOISE_SPUR_OUT,
    output logic REF_STAGE_ON_OUT,
    output logic PHASE_DETECTOR_REF_OUT,
    output logic FEEDBACK_PULSE_OUT,
    output logic LOCK_OUT
);
    // Add step to acc; wrap at limit and flag the wrap
    function automatic logic [FRAC_W:0] wrap_add(
        input logic [FRAC_W-1:0] acc,
        input logic [FRAC_W-1:0] step,
        input logic [FRAC_W-1:0] limit
    );
        logic [FRAC_W:0] sum;
        sum = {1'h0, acc} + {1'h0, step};
        if (sum >= {1'h0, limit}) begin
            wrap_add = {1'h1, FRAC_W'(sum - {1'h0, limit})};
        end else begin
            wrap_add = {1'h0, sum[FRAC_W-1:0]};
        end
    endfunction

    logic [WORD_W-1:0] shift_reg;
    logic strobe_sync, strobe_prev_reg, load_pulse, rf_sync, rf_prev_reg, rf_tick, fastlock_reg;
    logic load_select_reg, prescaler_reg, counters_held, ref_pulse_reg, ref_toggle_reg, carry_reg;
    logic fb_pulse_reg, fb_toggle_reg, locked, mon_out_reg, mon_oe_reg, ref_stage_on_reg;
    latch_sel_t load_sel;
    monitor_sel_t monitor_sel_reg;
    logic [INT_W-1:0] int_reg;
    logic [INT_W:0] n_cnt_reg, n_target;
    logic [FRAC_W-1:0] frac_reg, ref_acc_reg, frac_acc_reg;
    logic [FRAC_W:0] ref_next, frac_next;
    logic [MODULUS_W-1:0] modulus_buffer_reg, modulus_active_reg, fl_timer_reg;
    logic [RDIV_W-1:0] rdiv_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [NOISE_W-1:0] noise_reg;
    logic [1:0] fb_seen_reg, fb_total;
    logic [LOCK_CNT_W-1:0] lock_cnt_reg;

    // Serial shift register on the link clock
    always_ff @(posedge LINK.sclk) begin
        shift_reg <= {shift_reg[WORD_W-2:0], LINK.sdata};
    end

    // Strobe and RF pins into the reference domain
    level_sync strobe_sync_i (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .async_in(LINK.load_strobe),
        .sync_out(strobe_sync)
    );
    level_sync rf_sync_i (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .async_in(RF_IN),
        .sync_out(rf_sync)
    );

    // Edge detection on the synchronised levels
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            strobe_prev_reg <= 1'h0;
            rf_prev_reg <= 1'h0;
        end else begin
            strobe_prev_reg <= strobe_sync;
            rf_prev_reg <= rf_sync;
        end
    end
    assign load_pulse = strobe_sync & ~strobe_prev_reg;
    assign rf_tick = rf_sync & ~rf_prev_reg;
    // Shift word is quiet while the strobe is high, so it is read here
    assign load_sel = latch_sel_t'(shift_reg[SEL_MSB:SEL_LSB]);

    // Program latches
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            fastlock_reg <= 1'h0;
            int_reg <= INT_RESET;
            frac_reg <= FRAC_RESET;
            modulus_buffer_reg <= MODULUS_RESET;
            modulus_active_reg <= MODULUS_RESET;
            fl_timer_reg <= MODULUS_RESET;
            load_select_reg <= 1'h0;
            monitor_sel_reg <= MON_TRISTATE;
            prescaler_reg <= 1'h0;
            rdiv_reg <= RDIV_RESET;
            ctrl_reg <= CTRL_RESET;
            noise_reg <= NOISE_RESET;
        end else if (load_pulse) begin
            case (load_sel)
                SEL_INT_FRAC: begin
                    fastlock_reg <= shift_reg[FASTLOCK_BIT];
                    int_reg <= shift_reg[INT_MSB:INT_LSB];
                    frac_reg <= shift_reg[FRAC_MSB:FRAC_LSB];
                    modulus_active_reg <= modulus_buffer_reg;
                end
                SEL_REF_DIV: begin
                    load_select_reg <= shift_reg[LOADSEL_BIT];
                    monitor_sel_reg <= monitor_sel_t'(shift_reg[MONSEL_MSB:MONSEL_LSB]);
                    prescaler_reg <= shift_reg[PRESCALER_BIT];
                    rdiv_reg <= shift_reg[RDIV_MSB:RDIV_LSB];
                    if (shift_reg[LOADSEL_BIT]) begin
                        fl_timer_reg <= shift_reg[MODULUS_MSB:MODULUS_LSB];
                    end else begin
                        modulus_buffer_reg <= shift_reg[MODULUS_MSB:MODULUS_LSB];
                    end
                end
                SEL_LOOP_CTRL: begin
                    ctrl_reg <= shift_reg[CTRL_W-1:0];
                end
                SEL_NOISE_SPUR: begin
                    noise_reg <= shift_reg[NOISE_W-1:0];
                end
                default: noise_reg <= noise_reg;
            endcase
        end
    end

    // Power-down or counter reset stops both dividers
    assign counters_held = ctrl_reg[POWERDOWN_BIT] | ctrl_reg[CNT_RESET_BIT];

    // Reference stage connection follows power-down
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ref_stage_on_reg <= 1'h0;
        end else begin
            ref_stage_on_reg <= ~ctrl_reg[POWERDOWN_BIT];
        end
    end

    // Reference divider: rate is reference times (1+D)/R
    assign ref_next = wrap_add(ref_acc_reg, ACC_ONE + FRAC_W'(ctrl_reg[DOUBLER_BIT]), FRAC_W'(rdiv_reg));
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || counters_held || rdiv_reg == '0) begin
            ref_acc_reg <= '0;
            ref_pulse_reg <= 1'h0;
        end else begin
            ref_acc_reg <= ref_next[FRAC_W-1:0];
            ref_pulse_reg <= ref_next[FRAC_W];
        end
    end

    // Feedback divider: INT or INT+1 edges, fraction accumulator picks
    assign n_target = {1'h0, int_reg} + {{INT_W{1'h0}}, carry_reg};
    assign frac_next = wrap_add(frac_acc_reg, frac_reg, modulus_active_reg);
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || counters_held) begin
            n_cnt_reg <= '0;
            carry_reg <= 1'h0;
            frac_acc_reg <= '0;
            fb_pulse_reg <= 1'h0;
        end else if (rf_tick && (n_cnt_reg + COUNT_ONE >= n_target)) begin
            n_cnt_reg <= '0;
            carry_reg <= frac_next[FRAC_W];
            frac_acc_reg <= frac_next[FRAC_W-1:0];
            fb_pulse_reg <= 1'h1;
        end else begin
            n_cnt_reg <= rf_tick ? n_cnt_reg + COUNT_ONE : n_cnt_reg;
            fb_pulse_reg <= 1'h0;
        end
    end

    // Scaled divider outputs for the monitor
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ref_toggle_reg <= 1'h0;
            fb_toggle_reg <= 1'h0;
        end else begin
            ref_toggle_reg <= ref_toggle_reg ^ ref_pulse_reg;
            fb_toggle_reg <= fb_toggle_reg ^ fb_pulse_reg;
        end
    end

    // Lock detect: one feedback pulse per reference period, several in a row
    assign fb_total = (fb_seen_reg == 2'h3) ? fb_seen_reg : fb_seen_reg + {1'h0, fb_pulse_reg};
    assign locked = (lock_cnt_reg == LOCK_CNT_W'(LOCK_COUNT));
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || counters_held) begin
            fb_seen_reg <= 2'h0;
            lock_cnt_reg <= '0;
        end else if (ref_pulse_reg) begin
            fb_seen_reg <= 2'h0;
            if (fb_total != 2'h1) begin
                lock_cnt_reg <= '0;
            end else if (!locked) begin
                lock_cnt_reg <= lock_cnt_reg + LOCK_CNT_W'(1);
            end
        end else begin
            fb_seen_reg <= fb_total;
        end
    end

    // Monitor output multiplexer
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            mon_out_reg <= 1'h0;
            mon_oe_reg <= 1'h0;
        end else begin
            mon_oe_reg <= 1'h1;
            case (monitor_sel_reg)
                MON_TRISTATE: begin
                    mon_out_reg <= 1'h0;
                    mon_oe_reg <= 1'h0;
                end
                MON_DIG_LOCK: mon_out_reg <= locked;
                MON_N_DIV: mon_out_reg <= fb_toggle_reg;
                MON_HIGH: mon_out_reg <= 1'h1;
                MON_R_DIV: mon_out_reg <= ref_toggle_reg;
                MON_ANA_LOCK: begin
                    // Open drain: pull low except while locked between pulses
                    mon_out_reg <= 1'h0;
                    mon_oe_reg <= ~(locked & ~ref_pulse_reg);
                end
                default: mon_out_reg <= 1'h0;
            endcase
        end
    end

    // Outputs
    assign LINK.mon_out = mon_out_reg;
    assign LINK.mon_oe = mon_oe_reg;
    assign FASTLOCK_OUT = fastlock_reg;
    assign INT_VALUE_OUT = int_reg;
    assign FRAC_VALUE_OUT = frac_reg;
    assign MODULUS_VALUE_OUT = modulus_active_reg;
    assign REF_RATIO_OUT = rdiv_reg;
    assign PRESCALER_SELECT_OUT = prescaler_reg;
    assign LOOP_CONTROL_OUT = ctrl_reg;
    assign NOISE_SPUR_OUT = noise_reg;
    assign REF_STAGE_ON_OUT = ref_stage_on_reg;
    assign PHASE_DETECTOR_REF_OUT = ref_pulse_reg;
    assign FEEDBACK_PULSE_OUT = fb_pulse_reg;
    assign LOCK_OUT = locked;
endmodule // synth_program_latches
`default_nettype wire

// >>> src/synth_link_host.sv
// Host end: Wishbone register slave that shifts one word out over the
// three-wire link and reads back the monitor line.
// Assumes software keeps words and range limits legal for the device.
`timescale 1ns/10ps
`default_nettype none
module synth_link_host
    import synth_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [WB_ADR_W-1:0] WB_ADR_IN,
    input wire logic [WB_DAT_W-1:0] WB_DAT_IN,
    input wire logic [WB_SEL_W-1:0] WB_SEL_IN,
    output logic [WB_DAT_W-1:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    synth_serial_if.host LINK
);
    // Byte-lane merge of a write
    function automatic logic [WB_DAT_W-1:0] merge_bytes(
        input logic [WB_DAT_W-1:0] old_word,
        input logic [WB_DAT_W-1:0] new_word,
        input logic [WB_SEL_W-1:0] sel
    );
        logic [WB_DAT_W-1:0] result;
        result = old_word;
        for (int i = 0; i < WB_SEL_W; i++) begin
            if (sel[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        merge_bytes = result;
    endfunction

    logic ack_reg;
    logic wr_commit;
    logic [WB_DAT_W-1:0] tx_word_reg;
    logic short_reg;
    logic go_write;
    host_state_t state_reg;
    logic [DIV_W-1:0] div_cnt_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BIT_CNT_W-1:0] last_bit;
    logic sclk_reg;
    logic sdata_reg;
    logic strobe_reg;
    logic mon_sync;
    logic busy;

    assign busy = (state_reg != H_IDLE);
    // Write takes effect at the edge where the master samples ack
    assign wr_commit = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_reg;
    assign go_write = wr_commit && (WB_ADR_IN == ADDR_CTRL) && WB_SEL_IN[0] && WB_DAT_IN[CTRL_GO_BIT];
    assign last_bit = short_reg ? BIT_CNT_W'(SHORT_BITS - 1) : BIT_CNT_W'(WORD_W - 1);

    // Monitor line back into the host clock
    level_sync mon_sync_i (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .async_in(LINK.mon_level),
        .sync_out(mon_sync)
    );

    // Ack one cycle after request, read data registered with it
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ack_reg <= 1'h0;
            WB_DAT_OUT <= '0;
        end else begin
            ack_reg <= WB_CYC_IN & WB_STB_IN & ~ack_reg;
            if (WB_ADR_IN == ADDR_TX_WORD) begin
                WB_DAT_OUT <= tx_word_reg;
            end else if (WB_ADR_IN == ADDR_CTRL) begin
                WB_DAT_OUT <= WB_DAT_W'(short_reg) << CTRL_SHORT_BIT;
            end else if (WB_ADR_IN == ADDR_STATUS) begin
                WB_DAT_OUT <= (WB_DAT_W'(mon_sync) << STATUS_MON_BIT) | (WB_DAT_W'(busy) << STATUS_BUSY_BIT);
            end else begin
                WB_DAT_OUT <= '0;
            end
        end
    end
    assign WB_ACK_OUT = ack_reg;

    // Word and length registers, frozen while a frame runs
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            tx_word_reg <= '0;
            short_reg <= 1'h0;
        end else if (wr_commit && !busy) begin
            if (WB_ADR_IN == ADDR_TX_WORD) begin
                tx_word_reg <= merge_bytes(tx_word_reg, WB_DAT_IN, WB_SEL_IN) & WB_DAT_W'({WORD_W{1'h1}});
            end else if (WB_ADR_IN == ADDR_CTRL && WB_SEL_IN[0]) begin
                short_reg <= WB_DAT_IN[CTRL_SHORT_BIT];
            end
        end
    end

    // Frame sequencer: divided serial clock, MSB first, then strobe
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_reg <= H_IDLE;
            div_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            sclk_reg <= 1'h0;
            sdata_reg <= 1'h0;
            strobe_reg <= 1'h0;
        end else begin
            case (state_reg)
                H_IDLE: begin
                    div_cnt_reg <= '0;
                    bit_cnt_reg <= '0;
                    if (go_write) begin
                        state_reg <= H_SHIFT;
                        // Short control word sends 16 bits, long words 24
                        sdata_reg <= WB_DAT_IN[CTRL_SHORT_BIT] ? tx_word_reg[SHORT_BITS-1]
                                                             : tx_word_reg[WORD_W-1];
                    end
                end
                H_SHIFT: begin
                    div_cnt_reg <= div_cnt_reg + DIV_W'(1);
                    if (div_cnt_reg == DIV_W'(SCLK_DIV / 2 - 1)) begin
                        sclk_reg <= 1'h1;
                    end
                    if (div_cnt_reg == DIV_W'(SCLK_DIV - 1)) begin
                        sclk_reg <= 1'h0;
                        div_cnt_reg <= '0;
                        if (bit_cnt_reg == last_bit) begin
                            state_reg <= H_STROBE;
                            strobe_reg <= 1'h1;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
                            sdata_reg <= tx_word_reg[last_bit - bit_cnt_reg - BIT_CNT_W'(1)];
                        end
                    end
                end
                H_STROBE: begin
                    div_cnt_reg <= div_cnt_reg + DIV_W'(1);
                    if (div_cnt_reg == DIV_W'(SCLK_DIV - 1)) begin
                        strobe_reg <= 1'h0;
                        div_cnt_reg <= '0;
                        state_reg <= H_GAP;
                    end
                end
                H_GAP: begin
                    div_cnt_reg <= div_cnt_reg + DIV_W'(1);
                    if (div_cnt_reg == DIV_W'(SCLK_DIV - 1)) begin
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    assign LINK.sclk = sclk_reg;
    assign LINK.sdata = sdata_reg;
    assign LINK.load_strobe = strobe_reg;
endmodule // synth_link_host
`default_nettype wire

// >>> bench/synth_link_checker.sv
// Wire checks on the serial link, host clock domain.
// Assumes instantiation beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module synth_link_checker (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe
);
    logic [4:0] bits_reg;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Clock rises since the last strobe
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || load_strobe) bits_reg <= 5'h00;
        else if ($rose(sclk)) bits_reg <= bits_reg + 5'h01;
    end
    a_data_steady: assert property (sclk |-> $stable(sdata)) else $error("data moved");
    a_clock_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("high width");
    a_clock_low: assert property ($fell(sclk) |-> !sclk [*8]) else $error("low width");
    a_strobe_width: assert property ($rose(load_strobe) |-> load_strobe [*8] ##1 load_strobe [*8] ##1
        !load_strobe) else $error("strobe width");
    a_strobe_quiet: assert property (load_strobe |-> !sclk) else $error("clock in strobe");
    a_strobe_edge: assert property ($rose(load_strobe) |-> $past(sclk)) else $error("strobe late");
    a_gap_idle: assert property ($fell(load_strobe) |-> (!sclk && !load_strobe) [*8]) else $error("gap");
    a_bit_count: assert property ($rose(load_strobe) |-> bits_reg == 5'h18 || bits_reg == 5'h10)
        else $error("bit count");
endmodule // synth_link_checker
`default_nettype wire

// >>> bench/synth_serial_program_latches_test.sv
// Bench: Wishbone drives the host end; device latches compared with a model.
// Assumes both ends joined by the link interface.
`timescale 1ns/10ps
`default_nettype none
module synth_serial_program_latches_test
    import synth_pkg::*;
;
    logic clk = 0, rclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, fl, ps, ron, pdr, fbk, lk;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, dout, rd;
    logic [8:0] iv;
    logic [11:0] fv, mv;
    logic [3:0] rv;
    logic [15:0] lc, sd = 16'h1E3F;
    logic [10:0] ns;
    logic [23:0] w;
    logic [23:0] dir [6] = '{24'h34_C017, 24'h80_F48D, 24'hFF_C012, 24'h00_0812, 24'h00_0002, 24'h00_07FF};
    int num_errors = 0, cmp_count = 0, m_fl = 0, m_int = 31, m_frac = 0, m_mb = 2, m_ma = 2;
    int m_r = 1, m_ps = 0, m_ctl = 0, m_ns = 0, m_mon = 0;
    synth_serial_if link();
    synth_link_host i_synth_link_host (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(4'hF), .WB_DAT_OUT(dout),
        .WB_ACK_OUT(ack), .LINK(link.host));
    synth_program_latches i_synth_program_latches (.CLK_IN(rclk), .RST_IN(rst), .RF_IN(1'h0),
        .LINK(link.device), .FASTLOCK_OUT(fl), .INT_VALUE_OUT(iv), .FRAC_VALUE_OUT(fv),
        .MODULUS_VALUE_OUT(mv), .REF_RATIO_OUT(rv), .PRESCALER_SELECT_OUT(ps), .LOOP_CONTROL_OUT(lc),
        .NOISE_SPUR_OUT(ns), .REF_STAGE_ON_OUT(ron), .PHASE_DETECTOR_REF_OUT(pdr), .FEEDBACK_PULSE_OUT(fbk),
        .LOCK_OUT(lk));
    synth_link_checker i_synth_link_checker (.CLK_IN(clk), .RST_IN(rst), .sclk(link.sclk),
        .sdata(link.sdata), .load_strobe(link.load_strobe));
    // Host clock and unrelated device clock
    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #80 rclk = ~rclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One classic Wishbone cycle, read data left in rd
    task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= wr;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (ack !== 1'h1) num_errors++;
        rd = dout;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    // Send one word, update the model, compare all latches
    task send(input logic [23:0] x);
        int n;
        n = 0;
        wb(1'h1, ADDR_TX_WORD, {8'h00, x});
        wb(1'h0, ADDR_TX_WORD, 32'h0000_0000);
        chk(rd, {8'h00, x});
        wb(1'h1, ADDR_CTRL, {30'h0, x[1:0] == 2'h2, 1'h1});
        rd = 32'h0000_0001;
        while (rd[0] === 1'h1 && n < 900) begin
            wb(1'h0, ADDR_STATUS, 32'h0000_0000);
            n++;
        end
        if (n >= 900) num_errors++;
        repeat (4) @(posedge rclk);
        case (x[1:0])
            2'h0: begin
                m_fl = x[23];
                m_int = x[22:14];
                m_frac = x[13:2];
                m_ma = m_mb;
            end
            2'h1: begin
                m_r = x[17:14];
                m_ps = x[18];
                m_mon = x[22:20];
                if (!x[23]) m_mb = x[13:2];
            end
            2'h2: m_ctl = x[15:0];
            default: m_ns = x[10:0];
        endcase
        chk({fl, iv, fv}, {m_fl[0], m_int[8:0], m_frac[11:0]});
        chk({ps, rv, mv}, {m_ps[0], m_r[3:0], m_ma[11:0]});
        chk({ns, lc}, {m_ns[10:0], m_ctl[15:0]});
        chk(ron, !m_ctl[4]);
        if (m_mon == 0 || m_mon == 3) chk(link.mon_level, 1'h1);
        if (m_mon == 1 || m_mon > 4) chk(link.mon_level, 1'h0);
        chk({fbk, lk, pdr & (m_ctl[4] | m_ctl[2])}, 32'h0000_0000);
        $display("word %h done", x);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        #500000;
        num_errors++;
        end_of_test;
    end
    // Main sequence: reset values, directed words, random words
    initial begin
        repeat (3) @(posedge rclk);
        rst <= 1'h0;
        repeat (2) @(posedge rclk);
        chk({iv, mv, rv}, {INT_RESET, MODULUS_RESET, RDIV_RESET});
        wb(1'h0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("reset test done");
        foreach (dir[i]) send(dir[i]);
        for (int i = 0; i < 9; i++) begin
            sd = lfsr(sd);
            w[23:8] = sd;
            sd = lfsr(sd);
            w[7:0] = sd[7:0];
            w[1:0] = i[1:0];
            if (i[1:0] == 2'h0) w[13:2] = 12'(w[13:2] % m_mb);
            w[22] = w[22] | (i[1:0] == 2'h0);
            w[14] = w[14] | (i[1:0] == 2'h1);
            w[3] = w[3] | (i[1:0] == 2'h1);
            send(w);
        end
        end_of_test;
    end
endmodule // synth_serial_program_latches_test
`default_nettype wire
